// ==== bench/dhbi_checker.sv ====
// Purpose: Pin protocol assertions for the host bus interface
// Assumes: Only top-level ports are visible; one clock domain
// Notes:   Slave-role pin behaviour is not covered here
`timescale 1ns/1ps
module dhbi_checker (
   input wire logic aclk,                 // Clock
   input wire logic aresetn,              // Reset, active low
   input wire logic bus_req_n,            // Bus request
   input wire logic bus_grant_in,         // Grant, active low
   input wire logic read_dir_o,           // Direction value
   input wire logic read_dir_oe,          // Direction enable
   input wire logic xcvr_inbound_n,       // Inbound control
   input wire logic xcvr_outbound_n,      // Outbound control
   input wire logic xcvr_oe,              // Transceiver enable
   input wire logic data_strobe_n_o,      // Strobe value
   input wire logic data_strobe_n_oe,     // Strobe enable
   input wire logic mux_addr_data_bus_oe, // Bus enable
   input wire logic pin15_oe,             // Pin 15 enable
   input wire logic attention_irq_n_oe,   // Attention pull-down
   input wire logic irq                   // Level interrupt
);
   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);
   dir_master_a: assert property (read_dir_oe |-> !bus_grant_in)
      else $error("direction driven without grant");
   dir_steady_a: assert property (read_dir_oe && $past(read_dir_oe) |-> $stable(read_dir_o))
      else $error("direction changed in transaction");
   inbound_read_a: assert property (xcvr_oe && !xcvr_inbound_n |-> read_dir_o && !data_strobe_n_o)
      else $error("inbound control outside read data phase");
   outbound_write_a: assert property (xcvr_oe && !read_dir_o |-> !xcvr_outbound_n)
      else $error("outbound control dropped in write");
   outbound_read_a: assert property (xcvr_oe && read_dir_o && !data_strobe_n_o |-> xcvr_outbound_n)
      else $error("outbound control in read data phase");
   bus_release_a: assert property (read_dir_oe && read_dir_o && !data_strobe_n_o |-> !mux_addr_data_bus_oe)
      else $error("bus driven while taking data");
   strobe_master_a: assert property (data_strobe_n_oe |-> read_dir_oe)
      else $error("strobe driven outside master role");
   mask_master_a: assert property (pin15_oe |-> xcvr_oe)
      else $error("pin 15 driven outside master role");
   request_hold_a: assert property ($fell(bus_req_n) |-> !bus_req_n [*4])
      else $error("request released too early");
   attention_irq_a: assert property (attention_irq_n_oe == irq)
      else $error("attention pin differs from interrupt");
   cover property ($fell(bus_req_n));
   cover property (xcvr_oe && !xcvr_inbound_n);
   cover property ($rose(irq));
endmodule
bind dhbi_top dhbi_checker u_chk (.*);

// ==== bench/dhbi_mem_model.sv ====
// Purpose: Arbiter and memory on the far side of the host bus
// Assumes: Device pins change only after aclk edges
// Notes:   An undriven bus shows the inverse of its last level
`timescale 1ns/1ps
module dhbi_mem_model (
   input  wire logic        aclk,       // Clock
   input  wire logic        req_n,      // Bus request
   input  wire logic        force_gnt,  // Grant given to another master
   input  wire logic [3:0]  ready_wait, // Data phase wait states
   input  wire logic [15:0] bus_o,      // Device bus value
   input  wire logic        bus_oe,     // Device bus enable
   input  wire logic        dir,        // Direction
   input  wire logic        stb_n,      // Data strobe
   output logic             gnt_n,      // Grant, active low
   output logic             rdy_n,      // Ready, active low
   output logic [15:0]      bus_i,      // Resolved bus
   output logic [15:0]      adr,        // Last address phase value
   output logic [15:0]      wr_data,    // Last word written
   output int               xfers       // Completed data phases
);
   logic        own = 1'h0;
   logic        stb_q = 1'h1;
   logic [1:0]  rel = 2'h0;
   logic [3:0]  wcnt = 4'h0;
   logic [15:0] last = 16'h0000;
   assign gnt_n = !(own || force_gnt);
   // Memory drives only in its own read data phase
   assign bus_i = bus_oe ? bus_o : (own && dir && !stb_n) ? adr ^ 16'h5a5a : ~last;
   assign rdy_n = !(own && !stb_n && wcnt >= ready_wait);
   initial xfers = 0;
   always @(posedge aclk) begin
      last <= bus_i;
      stb_q <= stb_n;
      wcnt <= stb_n ? 4'h0 : wcnt + 4'h1;
      if (bus_oe && stb_n && stb_q) adr <= bus_o;
      if (bus_oe && !stb_n && !dir) wr_data <= bus_o;
      if (stb_n && !stb_q) xfers <= xfers + 1;
      if (!req_n) begin
         own <= 1'h1;
         rel <= 2'h0;
      end else if (own) begin
         rel <= rel + 2'h1;
         own <= rel != 2'h2; // Grant withdrawn only after release
      end
   end
endmodule

// ==== bench/dhbi_top_bench.sv ====
// Purpose: Self-checking bench for the host bus interface
// Assumes: AXI4-Lite register access, memory model on the pins
// Notes:   One task per scenario; pin timing judged by the checker
`timescale 1ns/1ps
module dhbi_top_bench;
   logic        aclk = 1'h0, aresetn = 1'h0, clk_en = 1'h1, force_gnt = 1'h0, pin15_i = 1'h1;
   logic        awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
   logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
   logic [31:0] wdata = 32'h0000_0000, rdata, rdv;
   logic [4:0]  event_in = 5'h00;
   logic [3:0]  ready_wait = 4'h0;
   logic [1:0]  bresp, rresp, rsp, bm_seen;
   logic [15:0] bus_o, bus_i, wr_data, mem_adr;
   logic        awready, wready, bvalid, arready, rvalid, bus_oe, dir_o, dir_oe, stb_o, stb_oe;
   logic        p15_o, p16_o, req_n, gnt_n, rdy_n, irq, att_oe;
   int          err_total = 0, checks = 0, cyc = 0, xfers;
   dhbi_top u_dut (
      .aclk(aclk), .aresetn(aresetn), .clk_en(clk_en), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
      .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
      .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
      .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .event_in(event_in),
      .mux_addr_data_bus_i(bus_i), .mux_addr_data_bus_o(bus_o), .mux_addr_data_bus_oe(bus_oe),
      .read_dir_o(dir_o), .read_dir_oe(dir_oe), .data_strobe_n_i(stb_o), .data_strobe_n_o(stb_o),
      .data_strobe_n_oe(stb_oe), .xcvr_inbound_n(), .xcvr_outbound_n(), .xcvr_oe(), .pin15_i(pin15_i),
      .pin15_o(p15_o), .pin15_oe(), .pin16_o(p16_o), .pin16_oe(), .bus_req_n(req_n), .bus_grant_in(gnt_n),
      .ready_n_i(rdy_n), .attention_irq_n_o(), .attention_irq_n_oe(att_oe), .irq(irq));
   dhbi_mem_model u_mem (
      .aclk(aclk), .req_n(req_n), .force_gnt(force_gnt), .ready_wait(ready_wait), .bus_o(bus_o),
      .bus_oe(bus_oe), .dir(dir_o), .stb_n(stb_o), .gnt_n(gnt_n), .rdy_n(rdy_n), .bus_i(bus_i),
      .adr(mem_adr), .wr_data(wr_data), .xfers(xfers));
   initial forever #10 aclk = ~aclk;
   always @(posedge aclk) if (!stb_o && stb_oe) bm_seen <= {p16_o, p15_o};
   always @(posedge aclk) begin
      cyc++;
      if (cyc == 20000) begin
         err_total++;
         complete_run();
      end
   end
   task automatic check(input logic [31:0] seen, exp, input string msg);
      checks++;
      if (seen !== exp) begin
         err_total++;
         $display("unexpected at %0t: %s seen %h want %h", $time, msg, seen, exp);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'h1;
      wvalid <= 1'h1;
      bready <= 1'h1;
      do begin
         @(posedge aclk);
         if (awready) awvalid <= 1'h0;
         if (wready) wvalid <= 1'h0;
      end while (awvalid || wvalid);
      do @(posedge aclk); while (!bvalid);
      rsp = bresp;
      bready <= 1'h0;
      @(posedge aclk);
   endtask
   task automatic rd(input logic [7:0] a);
      araddr <= a;
      arvalid <= 1'h1;
      rready <= 1'h1;
      do @(posedge aclk); while (!arready);
      arvalid <= 1'h0;
      do @(posedge aclk); while (!rvalid);
      rdv = rdata;
      rsp = rresp;
      rready <= 1'h0;
      @(posedge aclk);
   endtask
   task automatic wait_done();
      int n;
      n = 0;
      do begin
         rd(dhbi_pkg::ADDR_STATUS);
         n++;
      end while (rdv[dhbi_pkg::ST_DONE] !== 1'h1 && n < 100);
      check(rdv[dhbi_pkg::ST_DONE], 1'h1, "transfer done");
      wr(dhbi_pkg::ADDR_STATUS, 32'h0000_0020);
   endtask
   task automatic t_regs();
      rd(dhbi_pkg::ADDR_CONFIG);
      check(rdv, 32'h0000_0000, "config reset");
      wr(dhbi_pkg::ADDR_CONFIG, 32'h0000_0041);
      rd(dhbi_pkg::ADDR_CONFIG);
      check(rdv[6:0], 7'h41, "config readback");
      wr(8'h18, 32'h0000_ffff);
      check(rsp, dhbi_pkg::BRESP_ERR, "unmapped write");
      rd(8'h18);
      check(rsp, dhbi_pkg::BRESP_ERR, "unmapped read");
      $display("test regs done");
   endtask
   task automatic t_irq();
      wr(dhbi_pkg::ADDR_MASK, 32'h0000_001f);
      for (int i = 0; i < 6; i++) begin
         wr(dhbi_pkg::ADDR_STATUS, i < 5 ? 32'h0000_0200 : 32'h0000_0000);
         event_in <= 5'h01 << (i % 5);
         @(posedge aclk);
         event_in <= 5'h00;
         rd(dhbi_pkg::ADDR_STATUS);
         check(rdv[4:0], 5'h01 << (i % 5), "sticky flag");
         check({irq, att_oe}, i < 5 ? 2'h3 : 2'h0, "attention level");
         wr(dhbi_pkg::ADDR_STATUS, 32'h0000_0200 | (32'h0000_0001 << (i % 5)));
         rd(dhbi_pkg::ADDR_STATUS);
         check({rdv[4:0], irq}, 6'h00, "flag cleared");
      end
      wr(dhbi_pkg::ADDR_MASK, 32'h0000_0000);
      event_in <= 5'h02;
      @(posedge aclk);
      event_in <= 5'h00;
      rd(dhbi_pkg::ADDR_STATUS);
      check({rdv[1], irq}, 2'h2, "masked flag");
      wr(dhbi_pkg::ADDR_STATUS, 32'h0000_001f);
      $display("test irq done");
   endtask
   task automatic t_dma();
      logic [31:0] cmds [6] = '{32'h0000_1234, 32'h0001_1236, 32'h0003_2001, 32'h0002_2000,
                                32'h0003_3001, 32'h0000_3000};
      logic [1:0]  pins [6] = '{2'h0, 2'h0, 2'h1, 2'h2, 2'h3, 2'h2};
      for (int i = 0; i < 6; i++) begin
         wr(dhbi_pkg::ADDR_CONFIG, {31'h0000_0000, i > 3});
         ready_wait <= i % 2 ? 4'h5 : 4'h0;
         wr(dhbi_pkg::ADDR_DMADAT, 32'h0000_c3a5);
         wr(dhbi_pkg::ADDR_DMACMD, cmds[i]);
         wait_done();
         check(mem_adr, cmds[i][15:0], "address phase");
         check(bm_seen, pins[i], "byte select pins");
         rd(dhbi_pkg::ADDR_DMADAT);
         if (cmds[i][17:16] == 2'h1) check(wr_data, 16'hc3a5, "written word");
         if (cmds[i][17:16] == 2'h0) check(rdv[15:0], cmds[i][15:0] ^ 16'h5a5a, "read word");
      end
      $display("test dma done");
   endtask
   task automatic t_edge();
      int n;
      n = xfers;
      wr(dhbi_pkg::ADDR_CONFIG, 32'h0000_0001);
      wr(dhbi_pkg::ADDR_DMACMD, 32'h0000_3001);
      rd(dhbi_pkg::ADDR_STATUS);
      check(rdv[6:5], 2'h2, "illegal select refused");
      check(xfers - n, 0, "no bus cycle");
      wr(dhbi_pkg::ADDR_STATUS, 32'h0000_0040);
      force_gnt <= 1'h1;
      repeat (3) @(posedge aclk);
      check({p16_o, req_n}, 2'h1, "chain passes grant");
      force_gnt <= 1'h0;
      repeat (3) @(posedge aclk);
      check(p16_o, 1'h1, "chain idle high");
      wr(dhbi_pkg::ADDR_CONFIG, 32'h0000_0040);
      pin15_i <= 1'h0;
      n = xfers;
      wr(dhbi_pkg::ADDR_DMACMD, 32'h0004_4000);
      wait_done();
      repeat (20) @(posedge aclk);
      check(xfers - n, 1, "burst ends");
      check(req_n, 1'h1, "request released");
      pin15_i <= 1'h1;
      $display("test edge done");
   endtask
   task automatic complete_run();
      $display("checks %0d, mismatches %0d", checks, err_total);
      if (err_total == 0 && checks > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask
   initial begin
      repeat (20) @(posedge aclk);
      aresetn <= 1'h1;
      repeat (2) @(posedge aclk);
      t_regs();
      t_irq();
      t_dma();
      t_edge();
      complete_run();
   end
endmodule

// ==== rtl/dhbi_pkg.sv ====
// Purpose: Shared constants for the DMA host bus interface block
// Assumes: 32-bit AXI4-Lite register access, 50 MHz aclk
// Notes:   Register offsets are byte addresses
package dhbi_pkg;
   // ----------------------------------------
   // Register map
   // ----------------------------------------
   localparam logic [7:0] ADDR_STATUS = 8'h00;   // main_status_reg, sticky flags, W1C
   localparam logic [7:0] ADDR_CONFIG = 8'h04;   // bus_config_reg
   localparam logic [7:0] ADDR_MASK   = 8'h08;   // interrupt mask, same layout as status
   localparam logic [7:0] ADDR_DMACMD = 8'h0C;   // DMA request: write starts one transfer, or a burst when CMD_BURST is set
   localparam logic [7:0] ADDR_DMADAT = 8'h10;   // DMA data: write data / last read data
   localparam logic [7:0] ADDR_BUSST  = 8'h14;   // Live bus state, read only
   // ----------------------------------------
   // Status bit positions
   // ----------------------------------------
   localparam int ST_MISS = 0;
   localparam int ST_MEMORY_ERROR_FLAG = 1;   // memory_error_flag
   localparam int ST_RECEIVE_IRQ_FLAG = 2;   // receive_irq_flag
   localparam int ST_TRANSMIT_IRQ_FLAG = 3;   // transmit_irq_flag
   localparam int ST_PRIMITIVE_IRQ_FLAG = 4;   // primitive_irq_flag
   localparam int ST_DONE = 5;   // DMA transfer complete
   localparam int ST_ILL  = 6;   // Illegal byte selection refused
   localparam int ST_W    = 7;
   localparam int ST_IRQ_EN = 9; // irq_enable_bit
   localparam logic [15:0] ST_SRC_MASK = 16'h001F;
   // ----------------------------------------
   // Config bit positions
   // ----------------------------------------
   localparam int CF_BUS_CONTROL_SELECT   = 0;  // bus_control_select
   localparam int CF_BURST_RELEASE_IN = 6;  // pin 15 becomes burst_release_in
   // ----------------------------------------
   // DMA command fields
   // ----------------------------------------
   localparam int CMD_ADDR_LSB = 0;   // 16-bit memory address
   localparam int CMD_WRITE    = 16;  // 1 = write to memory
   localparam int CMD_BYTE     = 17;  // 1 = byte transfer
   localparam int CMD_BURST    = 18;  // 1 = repeat with address+2 until release
   // ----------------------------------------
   // Bus phase timing (cycles) and AXI response codes
   // ----------------------------------------
   localparam int ADDR_CYC = 2;
   localparam logic [1:0] BRESP_OK  = 2'b00;
   localparam logic [1:0] BRESP_ERR = 2'b10;
endpackage

// ==== rtl/dhbi_top.sv ====
// Purpose: Bus master/slave pin logic of an SDLC frame controller host port
// Assumes: All pin inputs synchronous to aclk; active-low strobes
// Notes:   Software starts DMA transfers; pins follow master role timing
// Functional notes
// - Address phase drives low 16 address bits; data phase carries data on same bus.
// - Direction pin driven only as master, valid all transaction, else released.
// - Direction high means device takes data; low means device places data.
// - Attention output asserts on any listed status flag, only with enable bit 09; code also needs the flag's mask_r bit set.
// - Inbound transceiver control asserted in read data phase only, master only.
// - Outbound control asserted in read address phase and whole write, master only.
// - Data strobe marks data phase; driven as master, input as slave, else released.
// - Config bit 06 makes pin 15 burst release input; burst ends after current transfer.
// - Select bit zero: two byte masks, LL word, LH upper, HL lower, HH none.
// - Byte masks driven only as master and ignored as slave.
// - Select bit one: byte line plus latched address bit 0 choose width.
// - Byte line driven only as master and ignored as slave.
// - Config bit 00 chooses pins 15/16 as masks or byte plus grant chain.
// - Grant chain output low on grant when not requesting; high if requesting.
// - Request bus when a cycle is needed and no grant; hold for whole transaction.
//
// The implementer's own choices: the AXI4-Lite interface to the registers and the address map.
`timescale 1ns/1ps
module dhbi_top (
   input  wire logic        aclk,               // Clock, 50 MHz
   input  wire logic        aresetn,            // Synchronous reset, active low
   input  wire logic        clk_en,             // Freezes all state when low
   input  wire logic [7:0]  s_axi_awaddr,       // Write address
   input  wire logic        s_axi_awvalid,      // Write address valid
   output logic             s_axi_awready,      // Write address ready
   input  wire logic [31:0] s_axi_wdata,        // Write data
   input  wire logic [3:0]  s_axi_wstrb,        // Write strobes
   input  wire logic        s_axi_wvalid,       // Write data valid
   output logic             s_axi_wready,       // Write data ready
   output logic [1:0]       s_axi_bresp,        // Write response
   output logic             s_axi_bvalid,       // Write response valid
   input  wire logic        s_axi_bready,       // Write response ready
   input  wire logic [7:0]  s_axi_araddr,       // Read address
   input  wire logic        s_axi_arvalid,      // Read address valid
   output logic             s_axi_arready,      // Read address ready
   output logic [31:0]      s_axi_rdata,        // Read data
   output logic [1:0]       s_axi_rresp,        // Read response
   output logic             s_axi_rvalid,       // Read data valid
   input  wire logic        s_axi_rready,       // Read data ready
   input  wire logic [4:0]  event_in,           // Pulses: miss, memory_error_flag, receive_irq_flag, transmit_irq_flag, primitive_irq_flag
   input  wire logic [15:0] mux_addr_data_bus_i,// Bus level seen at pins
   output logic [15:0]      mux_addr_data_bus_o,// Bus drive value
   output logic             mux_addr_data_bus_oe,// Bus drive enable
   output logic             read_dir_o,         // Direction, high = device takes data
   output logic             read_dir_oe,        // Direction drive enable
   input  wire logic        data_strobe_n_i,    // Data strobe level at pin
   output logic             data_strobe_n_o,    // Data strobe drive value
   output logic             data_strobe_n_oe,   // Data strobe drive enable
   output logic             xcvr_inbound_n,     // Transceiver inbound control
   output logic             xcvr_outbound_n,    // Transceiver outbound control
   output logic             xcvr_oe,            // Drive enable of both transceiver lines
   input  wire logic        pin15_i,            // Pin 15 level (burst_release_in)
   output logic             pin15_o,            // Pin 15 drive: byte_mask_lo or byte line
   output logic             pin15_oe,           // Pin 15 drive enable
   output logic             pin16_o,            // Pin 16: byte_mask_hi or grant_chain_out
   output logic             pin16_oe,           // Pin 16 drive enable
   output logic             bus_req_n,          // Bus request, active low
   input  wire logic        bus_grant_in,       // Bus grant, active low
   input  wire logic        ready_n_i,          // Memory ready, active low
   output logic             attention_irq_n_o,  // Attention pin drive value (always 0)
   output logic             attention_irq_n_oe, // Open drain: high pulls line low
   output logic             irq                 // Level interrupt
);
   // ----------------------------------------
   // State
   // ----------------------------------------
   typedef enum logic [5:0] {
      DHBI_IDLE  = 6'b00_0001,
      DHBI_REQ   = 6'b00_0010,
      DHBI_ADDR  = 6'b00_0100,
      DHBI_DATA  = 6'b00_1000,
      DHBI_END   = 6'b01_0000,
      DHBI_REL   = 6'b10_0000
   } dhbi_state_t;

   dhbi_state_t        state_r, state_nxt;
   logic [15:0]        status_r, mask_r, config_r;
   logic [18:0]        cmd_r;
   logic [15:0]        dma_dat_r;
   logic               pend_r;
   logic               release_r;
   logic [1:0]         cyc_r;
   logic               aw_got_r, w_got_r;
   logic [7:0]         awaddr_r;
   logic [31:0]        wdata_r;

   // ----------------------------------------
   // Decode
   // ----------------------------------------
   wire bus_control_select       = config_r[dhbi_pkg::CF_BUS_CONTROL_SELECT];
   wire relmode    = config_r[dhbi_pkg::CF_BURST_RELEASE_IN];
   wire is_wr      = cmd_r[dhbi_pkg::CMD_WRITE];
   wire is_byte    = cmd_r[dhbi_pkg::CMD_BYTE];
   wire a0         = cmd_r[dhbi_pkg::CMD_ADDR_LSB];
   wire master     = (state_r == DHBI_ADDR) || (state_r == DHBI_DATA) || (state_r == DHBI_END);
   wire granted    = ~bus_grant_in;
   wire wr_fire    = aw_got_r && w_got_r && !s_axi_bvalid;
   wire wr_status  = wr_fire && (awaddr_r == dhbi_pkg::ADDR_STATUS);
   wire wr_config  = wr_fire && (awaddr_r == dhbi_pkg::ADDR_CONFIG);
   wire wr_mask    = wr_fire && (awaddr_r == dhbi_pkg::ADDR_MASK);
   wire wr_dmacmd  = wr_fire && (awaddr_r == dhbi_pkg::ADDR_DMACMD);
   wire wr_dmadat  = wr_fire && (awaddr_r == dhbi_pkg::ADDR_DMADAT);
   wire wr_known   = wr_status | wr_config | wr_mask | wr_dmacmd | wr_dmadat;
   wire master_nxt = (state_nxt == DHBI_ADDR) || (state_nxt == DHBI_DATA) || (state_nxt == DHBI_END);
   wire wr_nxt     = is_wr && ((state_nxt == DHBI_DATA) || (state_nxt == DHBI_END));
   // Alternate scheme has no code for a word at an odd address
   wire illegal    = bus_control_select && !wdata_r[dhbi_pkg::CMD_BYTE] && wdata_r[dhbi_pkg::CMD_ADDR_LSB];
   wire done_ev    = (state_r == DHBI_END) && clk_en;
   wire ill_ev     = wr_dmacmd && illegal;
   wire [15:0] set_bits = {9'h000, ill_ev, done_ev, event_in};
   wire [15:0] clr_bits = wr_status ? wdata_r[15:0] : 16'h0000;
   // Mask codes: word 00, upper 01, lower 10 as {hi,lo}
   wire [1:0]  bm_code  = !is_byte ? 2'b00 : (a0 ? 2'b01 : 2'b10);
   wire        burst_more = cmd_r[dhbi_pkg::CMD_BURST] && !(relmode && release_r);
   wire        irq_nxt  = status_r[dhbi_pkg::ST_IRQ_EN]
                        && |(status_r & dhbi_pkg::ST_SRC_MASK & mask_r);
   wire [31:0] rd_mux =
      (s_axi_araddr == dhbi_pkg::ADDR_STATUS) ? {16'h0000, status_r} :
      (s_axi_araddr == dhbi_pkg::ADDR_CONFIG) ? {16'h0000, config_r} :
      (s_axi_araddr == dhbi_pkg::ADDR_MASK)   ? {16'h0000, mask_r}   :
      (s_axi_araddr == dhbi_pkg::ADDR_DMACMD) ? {13'h0000, cmd_r}    :
      (s_axi_araddr == dhbi_pkg::ADDR_DMADAT) ? {16'h0000, dma_dat_r} :
      (s_axi_araddr == dhbi_pkg::ADDR_BUSST)  ? {26'h000_0000, state_r} : 32'h0000_0000;
   wire rd_known = (s_axi_araddr == dhbi_pkg::ADDR_STATUS) || (s_axi_araddr == dhbi_pkg::ADDR_CONFIG)
                || (s_axi_araddr == dhbi_pkg::ADDR_MASK) || (s_axi_araddr == dhbi_pkg::ADDR_DMACMD)
                || (s_axi_araddr == dhbi_pkg::ADDR_DMADAT) || (s_axi_araddr == dhbi_pkg::ADDR_BUSST);

   // ----------------------------------------
   // Bus master sequencer
   // ----------------------------------------
   always_comb begin
      state_nxt = state_r;
      case (state_r)
         DHBI_IDLE: if (pend_r && !granted) state_nxt = DHBI_REQ;
         DHBI_REQ:  if (granted) state_nxt = DHBI_ADDR;
         DHBI_ADDR: if (cyc_r == 2'(dhbi_pkg::ADDR_CYC - 1)) state_nxt = DHBI_DATA;
         DHBI_DATA: if (!ready_n_i) state_nxt = DHBI_END;
         DHBI_END:  state_nxt = burst_more ? DHBI_ADDR : DHBI_REL;
         DHBI_REL:  state_nxt = DHBI_IDLE;
         default:   state_nxt = DHBI_IDLE;
      endcase
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         state_r <= DHBI_IDLE;
         cyc_r   <= 2'b00;
      end else if (clk_en) begin
         state_r <= state_nxt;
         cyc_r   <= (state_r == DHBI_ADDR) ? cyc_r + 2'b01 : 2'b00;
      end
   end

   // ----------------------------------------
   // Registers and AXI4-Lite slave
   // ----------------------------------------
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         status_r  <= 16'h0000;
         mask_r    <= 16'h0000;
         config_r  <= 16'h0000;
         cmd_r     <= 19'h0_0000;
         dma_dat_r <= 16'h0000;
         pend_r    <= 1'b0;
         release_r <= 1'b0;
         aw_got_r  <= 1'b0;
         w_got_r   <= 1'b0;
         awaddr_r  <= 8'h00;
         wdata_r   <= 32'h0000_0000;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= dhbi_pkg::BRESP_OK;
         s_axi_rvalid <= 1'b0;
         s_axi_rresp  <= dhbi_pkg::BRESP_OK;
         s_axi_rdata  <= 32'h0000_0000;
      end else if (clk_en) begin
         // Set wins over a same-cycle clear
         status_r[dhbi_pkg::ST_W-1:0] <= (status_r[dhbi_pkg::ST_W-1:0] & ~clr_bits[dhbi_pkg::ST_W-1:0])
                                       | set_bits[dhbi_pkg::ST_W-1:0];
         if (wr_status) status_r[dhbi_pkg::ST_IRQ_EN] <= wdata_r[dhbi_pkg::ST_IRQ_EN];
         if (wr_mask)   mask_r   <= wdata_r[15:0];
         if (wr_config) config_r <= wdata_r[15:0];
         if (s_axi_awvalid && s_axi_awready) begin
            aw_got_r <= 1'b1;
            awaddr_r <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_got_r <= 1'b1;
            wdata_r <= s_axi_wdata;
         end
         if (wr_fire) begin
            aw_got_r     <= 1'b0;
            w_got_r      <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= wr_known ? dhbi_pkg::BRESP_OK : dhbi_pkg::BRESP_ERR;
         end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
         if (wr_dmacmd && !pend_r && !ill_ev) begin
            cmd_r     <= wdata_r[18:0];
            pend_r    <= 1'b1;
            release_r <= 1'b0;
         end else if (state_r == DHBI_REL) begin
            pend_r <= 1'b0;
         end
         if (wr_dmadat && !pend_r) dma_dat_r <= wdata_r[15:0];
         // Release request latched until the next DMA command is accepted
         if (master && relmode && !pin15_i) release_r <= 1'b1;
         if ((state_r == DHBI_DATA) && !ready_n_i && !is_wr) dma_dat_r <= mux_addr_data_bus_i;
         // Step early so a burst's next address phase already shows it
         if ((state_r == DHBI_DATA) && !ready_n_i) cmd_r[15:0] <= cmd_r[15:0] + 16'h0002;
         if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata  <= rd_mux;
            s_axi_rresp  <= rd_known ? dhbi_pkg::BRESP_OK : dhbi_pkg::BRESP_ERR;
         end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
      end
   end

   // ----------------------------------------
   // Pin drive (all registered)
   // ----------------------------------------
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_awready        <= 1'b0;
         s_axi_wready         <= 1'b0;
         s_axi_arready        <= 1'b0;
         mux_addr_data_bus_o  <= 16'h0000;
         mux_addr_data_bus_oe <= 1'b0;
         read_dir_o           <= 1'b1;
         read_dir_oe          <= 1'b0;
         data_strobe_n_o      <= 1'b1;
         data_strobe_n_oe     <= 1'b0;
         xcvr_inbound_n       <= 1'b1;
         xcvr_outbound_n      <= 1'b1;
         xcvr_oe              <= 1'b0;
         pin15_o              <= 1'b1;
         pin15_oe             <= 1'b0;
         pin16_o              <= 1'b1;
         pin16_oe             <= 1'b0;
         bus_req_n            <= 1'b1;
         attention_irq_n_o    <= 1'b0;
         attention_irq_n_oe   <= 1'b0;
         irq                  <= 1'b0;
      end else if (clk_en) begin
         s_axi_awready <= !aw_got_r && !(s_axi_awvalid && s_axi_awready) && !s_axi_bvalid;
         s_axi_wready  <= !w_got_r && !(s_axi_wvalid && s_axi_wready) && !s_axi_bvalid;
         s_axi_arready <= !s_axi_rvalid && !(s_axi_arvalid && s_axi_arready);
         // Address phase then data phase on one bus
         mux_addr_data_bus_o  <= (state_nxt == DHBI_ADDR) ? cmd_r[15:0] : dma_dat_r;
         mux_addr_data_bus_oe <= (state_nxt == DHBI_ADDR) || wr_nxt;
         read_dir_o  <= !is_wr;
         read_dir_oe <= master_nxt;
         data_strobe_n_o  <= !(state_nxt == DHBI_DATA);
         data_strobe_n_oe <= master_nxt;
         xcvr_inbound_n  <= !(!is_wr && (state_nxt == DHBI_DATA));
         xcvr_outbound_n <= !((state_nxt == DHBI_ADDR) || wr_nxt);
         xcvr_oe <= master_nxt;
         // Pin 15: byte line or low mask; input when release mode is on
         pin15_o  <= bus_control_select ? is_byte : bm_code[0];
         pin15_oe <= !relmode && master_nxt;
         // Pin 16: high mask as master, or chained grant as always-driven output
         if (bus_control_select) begin
            pin16_o  <= !(granted && (state_r == DHBI_IDLE) && !pend_r);
            pin16_oe <= 1'b1;
         end else begin
            pin16_o  <= bm_code[1];
            pin16_oe <= master_nxt;
         end
         bus_req_n <= !((state_nxt == DHBI_REQ) || master_nxt);
         attention_irq_n_oe <= irq_nxt;
         irq <= irq_nxt;
      end
   end
endmodule
